/* csc_pkg.sv */
// constants and rule summary of the conditional search control block
// Function
// - bit 0 picks pins or activity latches
// - bit 1 picks OR or AND combine
// - bit 2 picks reset input or strobe
// - power-on flag cleared only by write
// - power-on flag forces search response
// - bit 7 shows supply status, read-only
// - bits 4 to 6 read zero always
// - control/status resets to 08h
// - control/status written only by search write
// - masked channels compared against polarity bits
// - AND and OR combiners, term selects
// - AND needs every selected channel match
// - control commands only after ROM command
// - standard speed unless overdrive flag set
// - page read: two address bytes, up to 008Fh
// - inverted CRC16 after page end
// - ones after CRC until bus reset
// - pin sample timing for logic-state byte
// - channel read streams, CRC every 32
// - bus reset abandons channel read
// - mask and polarity reset to 00h
// - 008Eh and 008Fh read FFh
// - search write accepts 008Bh..008Dh only
package csc_pkg;
  // ----------------------------------------
  // commands and addresses
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_PAGE = 8'hF0;
  localparam logic [7:0] CMD_CHAN_READ = 8'hF5;
  localparam logic [7:0] CMD_SEARCH_WRITE = 8'hCC;
  localparam logic [15:0] ADDR_LOGIC = 16'h0088;
  localparam logic [15:0] ADDR_OUT_LATCH = 16'h0089;
  localparam logic [15:0] ADDR_ACTIVITY = 16'h008A;
  localparam logic [15:0] ADDR_MASK = 16'h008B;
  localparam logic [15:0] ADDR_POLARITY = 16'h008C;
  localparam logic [15:0] ADDR_CONTROL = 16'h008D;
  localparam logic [15:0] ADDR_PAGE_END = 16'h008F;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  // ----------------------------------------
  // control/status fields
  // ----------------------------------------
  localparam int BIT_SOURCE = 0;
  localparam int BIT_COMBINE = 1;
  localparam int BIT_ROLE = 2;
  localparam int BIT_POWER_ON = 3;
  localparam int BIT_SUPPLY = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] CONTROL_WMASK = 8'h0F;
  localparam logic [5:0] SAMPLES_PER_CRC = 6'h20;
  localparam logic [15:0] CRC_POLY_REV = 16'hA001;
  localparam logic [15:0] CRC_CLEAR = 16'h0000;
  // ----------------------------------------
  // master side command codes
  // ----------------------------------------
  localparam logic [1:0] OP_READ_PAGE = 2'h0;
  localparam logic [1:0] OP_CHAN_READ = 2'h1;
  localparam logic [1:0] OP_SEARCH_WRITE = 2'h2;
  // avalon register offsets of the master controller (word index)
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA = 3'h4;
  localparam logic [31:0] BAD_READ = 32'hDEADBEEF;
endpackage : csc_pkg

/* csc_link_if.sv */
// byte-level link between the master controller and the device control block
`timescale 1ns/100ps
interface csc_link_if;
  logic bus_reset; // one-cycle bus reset event
  logic rom_done; // one-cycle ROM stage complete
  logic m_valid; // master byte pulse
  logic [7:0] m_byte;
  logic rd_req; // master requests one byte
  logic d_valid; // device answer byte pulse
  logic [7:0] d_byte;
  logic d_sample; // pin sample moment, pulse
  logic overdrive_flag;
  modport master (output bus_reset, output rom_done, output m_valid, output m_byte, output rd_req,
    output overdrive_flag, input d_valid, input d_byte, input d_sample);
  modport device (input bus_reset, input rom_done, input m_valid, input m_byte, input rd_req,
    input overdrive_flag, output d_valid, output d_byte, output d_sample);
endinterface : csc_link_if

/* csc_device.sv */
// device end: register page, conditional search and read streams
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
module csc_device (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  csc_link_if.device link,
  input wire logic [7:0] I_PINS,
  input wire logic [7:0] I_ACTIVITY,
  input wire logic [7:0] I_OUT_LATCH,
  input wire logic I_SUPPLY,
  output logic O_SEARCH_RESPONSE,
  output logic O_STROBE_ROLE,
  output logic O_OVERDRIVE,
  output logic O_SAMPLE
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_ALO = 3'b010, ST_AHI = 3'b011,
    ST_PAGE = 3'b100, ST_CRC = 3'b101, ST_ONES = 3'b110, ST_WRITE = 3'b111
  } csc_state_e;
  typedef struct packed {
    csc_state_e st;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] mask;
    logic [7:0] polarity;
    logic [3:0] control;
    logic [15:0] crc;
    logic crc_half;
    logic chan;
    logic [5:0] count;
    logic [7:0] snap;
    logic d_valid;
    logic [7:0] d_byte;
    logic sample;
    logic response;
    logic [16:0] in_s1; // supply, activity latches, pins
    logic [16:0] in_s2;
    logic [16:0] in_s3;
    logic [16:0] in_f; // settled pin inputs
  } csc_dev_s;
  csc_dev_s cur;
  csc_dev_s nxt;
  logic [7:0] src;
  logic [7:0] hit;
  // ----------------------------------------
  // helper
  // ----------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ csc_pkg::CRC_POLY_REV) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
  function automatic logic [7:0] page_byte(input csc_dev_s s, input logic [15:0] a);
    logic [7:0] v;
    v = csc_pkg::FILL_BYTE;
    case (a)
      csc_pkg::ADDR_LOGIC: v = s.snap;
      csc_pkg::ADDR_OUT_LATCH: v = I_OUT_LATCH;
      csc_pkg::ADDR_ACTIVITY: v = s.in_f[15:8];
      csc_pkg::ADDR_MASK: v = s.mask;
      csc_pkg::ADDR_POLARITY: v = s.polarity;
      csc_pkg::ADDR_CONTROL: v = {s.in_f[16], 3'h0, s.control};
      default: v = (a < csc_pkg::ADDR_LOGIC) ? csc_pkg::FILL_BYTE : csc_pkg::FILL_BYTE;
    endcase
    return v;
  endfunction : page_byte
  // ----------------------------------------
  // search qualifier
  // ----------------------------------------
  // source pick, per-channel compare against polarity
  always_comb begin
    src = cur.control[csc_pkg::BIT_SOURCE] ? cur.in_f[15:8] : cur.in_f[7:0];
    hit = ~(src ^ cur.polarity);
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt = cur;
    nxt.d_valid = 1'b0;
    nxt.sample = 1'b0;
    // three-stage capture of the pins; a bit moves on only once stages two and three agree
    nxt.in_s1 = {I_SUPPLY, I_ACTIVITY, I_PINS};
    nxt.in_s2 = cur.in_s1;
    nxt.in_s3 = cur.in_s2;
    nxt.in_f = (cur.in_s2 & cur.in_s3) | (cur.in_f & (cur.in_s2 | cur.in_s3));
    // AND/OR combine, power-on flag forces an answer
    nxt.response = cur.control[csc_pkg::BIT_POWER_ON]
      | (cur.control[csc_pkg::BIT_COMBINE] ? (((hit | ~cur.mask) == 8'hFF) && (cur.mask != 8'h00))
      : |(hit & cur.mask));
    if (link.bus_reset) begin
      nxt.st = ST_IDLE;
    end else begin
      case (cur.st)
        ST_IDLE: begin
          if (link.rom_done) begin
            nxt.st = ST_CMD;
          end
        end
        ST_CMD: begin
          if (link.m_valid) begin
            nxt.cmd = link.m_byte;
            nxt.crc = crc_byte(csc_pkg::CRC_CLEAR, link.m_byte);
            nxt.count = 6'h00;
            nxt.crc_half = 1'b0;
            if (link.m_byte == csc_pkg::CMD_CHAN_READ) begin
              nxt.chan = 1'b1;
              nxt.snap = cur.in_f[7:0];
              nxt.sample = 1'b1;
              nxt.st = ST_PAGE;
            end else if (link.m_byte == csc_pkg::CMD_READ_PAGE || link.m_byte == csc_pkg::CMD_SEARCH_WRITE) begin
              nxt.chan = 1'b0;
              nxt.st = ST_ALO;
            end else begin
              nxt.st = ST_ONES;
            end
          end
        end
        ST_ALO: begin
          if (link.m_valid) begin
            nxt.addr[7:0] = link.m_byte;
            nxt.crc = crc_byte(cur.crc, link.m_byte);
            nxt.st = ST_AHI;
          end
        end
        ST_AHI: begin
          if (link.m_valid) begin
            nxt.addr[15:8] = link.m_byte;
            nxt.crc = crc_byte(cur.crc, link.m_byte);
            nxt.st = (cur.cmd == csc_pkg::CMD_SEARCH_WRITE) ? ST_WRITE : ST_PAGE;
            if (cur.cmd == csc_pkg::CMD_READ_PAGE && {link.m_byte, cur.addr[7:0]} <= csc_pkg::ADDR_LOGIC) begin
              nxt.snap = cur.in_f[7:0];
              nxt.sample = 1'b1;
            end
          end
        end
        ST_PAGE: begin
          if (link.rd_req) begin
            nxt.d_valid = 1'b1;
            if (cur.chan) begin
              nxt.d_byte = cur.snap;
              nxt.crc = crc_byte(cur.crc, cur.snap);
              nxt.count = cur.count + 6'h01;
              if (cur.count + 6'h01 == csc_pkg::SAMPLES_PER_CRC) begin
                nxt.st = ST_CRC;
              end else begin
                nxt.snap = cur.in_f[7:0];
                nxt.sample = 1'b1;
              end
            end else begin
              nxt.d_byte = page_byte(cur, cur.addr);
              nxt.crc = crc_byte(cur.crc, nxt.d_byte);
              nxt.addr = cur.addr + 16'h0001;
              if (cur.addr >= csc_pkg::ADDR_PAGE_END) begin
                nxt.st = ST_CRC;
              end
            end
          end
        end
        ST_CRC: begin
          if (link.rd_req) begin
            nxt.d_valid = 1'b1;
            nxt.d_byte = cur.crc_half ? ~cur.crc[15:8] : ~cur.crc[7:0];
            nxt.crc_half = ~cur.crc_half;
            if (cur.crc_half) begin
              if (cur.chan) begin
                nxt.crc = csc_pkg::CRC_CLEAR;
                nxt.count = 6'h00;
                nxt.snap = cur.in_f[7:0];
                nxt.sample = 1'b1;
                nxt.st = ST_PAGE;
              end else begin
                nxt.st = ST_ONES;
              end
            end
          end
        end
        ST_ONES: begin
          if (link.rd_req) begin
            nxt.d_valid = 1'b1;
            nxt.d_byte = csc_pkg::FILL_BYTE;
          end
        end
        ST_WRITE: begin
          if (link.m_valid) begin
            // only mask, polarity and control take writes
            case (cur.addr)
              csc_pkg::ADDR_MASK: nxt.mask = link.m_byte;
              csc_pkg::ADDR_POLARITY: nxt.polarity = link.m_byte;
              csc_pkg::ADDR_CONTROL: nxt.control = link.m_byte[3:0];
              default: nxt.control = cur.control;
            endcase
            if (cur.addr >= csc_pkg::ADDR_MASK && cur.addr < csc_pkg::ADDR_CONTROL) begin
              nxt.addr = cur.addr + 16'h0001;
            end else begin
              nxt.addr = 16'hFFFF; // later bytes ignored
            end
          end
        end
        default: nxt.st = ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cur <= '0;
      cur.st <= ST_IDLE;
      cur.mask <= csc_pkg::RESET_ZERO;
      cur.polarity <= csc_pkg::RESET_ZERO;
      cur.control <= csc_pkg::CONTROL_RESET[3:0];
    end else begin
      cur <= nxt;
    end
  end
  // outputs straight from flip-flops
  assign O_SEARCH_RESPONSE = cur.response;
  assign O_STROBE_ROLE = cur.control[csc_pkg::BIT_ROLE];
  assign O_OVERDRIVE = link.overdrive_flag;
  assign O_SAMPLE = cur.sample;
  assign link.d_valid = cur.d_valid;
  assign link.d_byte = cur.d_byte;
  assign link.d_sample = cur.sample;
endmodule : csc_device

/* csc_master.sv */
// master end: avalon-mm command registers driving the byte link
`timescale 1ns/100ps
module csc_master (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  csc_link_if.master link,
  input wire logic [2:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);
  typedef struct packed {
    logic busy;
    logic [2:0] step;
    logic [1:0] op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic overdrive;
    logic bus_reset;
    logic rom_done;
    logic m_valid;
    logic [7:0] m_byte;
    logic rd_req;
    logic wait_rd;
    logic [31:0] readdata;
    logic ack;
  } csc_mst_s;
  csc_mst_s cur;
  csc_mst_s nxt;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt = cur;
    nxt.bus_reset = 1'b0;
    nxt.rom_done = 1'b0;
    nxt.m_valid = 1'b0;
    nxt.rd_req = 1'b0;
    nxt.ack = 1'b0;
    // answer byte first, so a read request in the same cycle wins
    if (link.d_valid) begin
      nxt.rdata = link.d_byte;
      nxt.wait_rd = 1'b0;
    end
    // bus slave answers one cycle after the request
    if ((I_AVS_READ || I_AVS_WRITE) && !cur.ack) begin
      nxt.ack = 1'b1;
      if (I_AVS_WRITE) begin
        case (I_AVS_ADDRESS)
          csc_pkg::REG_CMD: begin
            // bit 8 reset, bit 9 read one byte, bits 1:0 start operation
            if (I_AVS_WRITEDATA[8]) begin
              nxt.bus_reset = 1'b1;
              nxt.busy = 1'b0;
            end else if (I_AVS_WRITEDATA[9] && !cur.busy) begin
              nxt.rd_req = 1'b1;
              nxt.wait_rd = 1'b1;
            end else if (I_AVS_WRITEDATA[10] && !cur.busy) begin
              nxt.m_valid = 1'b1; // extra write byte
              nxt.m_byte = cur.wdata;
            end else if (!cur.busy) begin
              nxt.busy = 1'b1;
              nxt.op = I_AVS_WRITEDATA[1:0];
              nxt.step = 3'h0;
              nxt.overdrive = I_AVS_WRITEDATA[4];
            end
          end
          csc_pkg::REG_ADDR: nxt.addr = I_AVS_WRITEDATA[15:0];
          csc_pkg::REG_WDATA: nxt.wdata = I_AVS_WRITEDATA[7:0];
          default: nxt.ack = 1'b1;
        endcase
      end else begin
        case (I_AVS_ADDRESS)
          csc_pkg::REG_STATUS: nxt.readdata = {30'h0, cur.wait_rd, cur.busy};
          csc_pkg::REG_RDATA: nxt.readdata = {24'h0, cur.rdata};
          csc_pkg::REG_ADDR: nxt.readdata = {16'h0, cur.addr};
          csc_pkg::REG_WDATA: nxt.readdata = {24'h0, cur.wdata};
          default: nxt.readdata = csc_pkg::BAD_READ;
        endcase
      end
    end
    // command sequencer: rom stage, command, address, data
    if (cur.busy) begin
      nxt.step = cur.step + 3'h1;
      case (cur.step)
        3'h0: nxt.rom_done = 1'b1;
        3'h1: begin
          nxt.m_valid = 1'b1;
          nxt.m_byte = (cur.op == csc_pkg::OP_CHAN_READ) ? csc_pkg::CMD_CHAN_READ
            : (cur.op == csc_pkg::OP_SEARCH_WRITE) ? csc_pkg::CMD_SEARCH_WRITE : csc_pkg::CMD_READ_PAGE;
          if (cur.op == csc_pkg::OP_CHAN_READ) begin
            nxt.busy = 1'b0;
          end
        end
        3'h2: begin
          nxt.m_valid = 1'b1;
          nxt.m_byte = cur.addr[7:0];
        end
        3'h3: begin
          nxt.m_valid = 1'b1;
          nxt.m_byte = cur.addr[15:8];
          nxt.busy = (cur.op == csc_pkg::OP_SEARCH_WRITE);
        end
        default: begin
          nxt.m_valid = 1'b1;
          nxt.m_byte = cur.wdata;
          nxt.busy = 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end
  assign O_AVS_READDATA = cur.readdata;
  assign O_AVS_WAITREQUEST = ~cur.ack;
  assign link.bus_reset = cur.bus_reset;
  assign link.rom_done = cur.rom_done;
  assign link.m_valid = cur.m_valid;
  assign link.m_byte = cur.m_byte;
  assign link.rd_req = cur.rd_req;
  assign link.overdrive_flag = cur.overdrive;
endmodule : csc_master

/* csc_chk.sv */
// concurrent checks on the byte link between the master and the device
`timescale 1ns/100ps
module csc_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic bus_reset,
  input wire logic rom_done,
  input wire logic m_valid,
  input wire logic [7:0] m_byte,
  input wire logic rd_req,
  input wire logic d_valid,
  input wire logic [7:0] d_byte,
  input wire logic d_sample,
  input wire logic overdrive_flag
);
  logic [7:0] cmd;
  logic [1:0] nb;
  logic [15:0] cur;
  logic [15:0] crc;
  logic [5:0] pos;
  logic rom_seen;
  logic pg;
  // reflected crc16 step over one byte, low bit first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ csc_pkg::CRC_POLY_REV : r >> 1;
    return r;
  endfunction : crc_upd
  // page read answer byte, cur holds its address
  assign pg = d_valid && cmd == csc_pkg::CMD_READ_PAGE && nb == 2'h3;
  // track command, target, stream position and running crc
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cmd <= 8'h00;
      nb <= 2'h0;
      cur <= 16'h0000;
      crc <= 16'h0000;
      pos <= 6'h00;
      rom_seen <= 1'b0;
    end else if (bus_reset || rom_done) begin
      cmd <= 8'h00;
      nb <= 2'h0;
      crc <= 16'h0000;
      pos <= 6'h00;
      rom_seen <= rom_done;
    end else if (m_valid && nb != 2'h3) begin
      nb <= nb + 2'h1;
      crc <= crc_upd(crc, m_byte);
      if (nb == 2'h0) cmd <= m_byte;
      if (nb == 2'h1) cur[7:0] <= m_byte;
      if (nb == 2'h2) cur[15:8] <= m_byte;
    end else if (d_valid && cmd == csc_pkg::CMD_CHAN_READ) begin
      pos <= (pos == 6'h21) ? 6'h00 : pos + 6'h01;
      crc <= (pos == 6'h21) ? 16'h0000 : (pos < 6'h20) ? crc_upd(crc, d_byte) : crc;
    end else if (pg) begin
      cur <= cur + 16'h0001;
      if (cur <= csc_pkg::ADDR_PAGE_END) crc <= crc_upd(crc, d_byte);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  rd_answer_a: assert property (rd_req |=> d_valid)
    else $error("read request not answered in the next cycle");
  no_stray_a: assert property (d_valid |-> $past(rd_req))
    else $error("answer byte without a read request");
  rom_first_a: assert property (m_valid |-> rom_seen)
    else $error("command byte before rom stage done");
  page_fill_a: assert property (pg && cur[15:1] == 15'h0047 |-> d_byte == csc_pkg::FILL_BYTE)
    else $error("page end bytes not all ones");
  page_crc_a: assert property (pg && cur[15:1] == 15'h0048 |-> d_byte == ~(cur[0] ? crc[15:8] : crc[7:0]))
    else $error("page read crc wrong");
  tail_ones_a: assert property (pg && cur > 16'h0091 |-> d_byte == 8'hFF)
    else $error("byte after page crc not all ones");
  chan_crc_a: assert property (d_valid && cmd == csc_pkg::CMD_CHAN_READ && pos[5] |->
    d_byte == ~(pos[0] ? crc[15:8] : crc[7:0]))
    else $error("channel read crc wrong");
  reset_quiet_a: assert property (bus_reset |=> !d_sample [*2])
    else $error("pin sample after bus reset");
  sample_when_a: assert property (d_sample |-> cmd == csc_pkg::CMD_CHAN_READ ||
    (cmd == csc_pkg::CMD_READ_PAGE && cur <= csc_pkg::ADDR_LOGIC))
    else $error("pin sample outside a sampling read");
  od_hold_a: assert property (m_valid |-> $stable(overdrive_flag))
    else $error("speed changed inside a command");
endmodule : csc_chk

/* csc_tb_top.sv */
// self-checking bench: master and device joined by the link, driven over avalon
`timescale 1ns/100ps
module csc_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pins = 8'h3C;
  logic [7:0] act = 8'h00;
  logic [7:0] latch = 8'hA5;
  logic supply = 1'b0;
  logic [2:0] av_addr = 3'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic resp;
  logic strobe_output_role;
  logic od;
  logic samp;
  logic [7:0] expb [8];
  logic [31:0] tbl [8] = '{32'h07000101, 32'h07000500, 32'h06010001, 32'h06050000,
    32'h04050001, 32'h04040000, 32'h05000001, 32'h05000400};
  int mismatches = 0;
  int n_checks = 0;
  int n_samp = 0;
  csc_link_if link ();
  csc_master i_csc_master (.I_CORE_CLK(clk), .I_RST_N(rst_n), .link(link), .I_AVS_ADDRESS(av_addr),
    .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(av_rdata),
    .O_AVS_WAITREQUEST(av_wait));
  csc_device i_csc_device (.I_CORE_CLK(clk), .I_RST_N(rst_n), .link(link), .I_PINS(pins), .I_ACTIVITY(act),
    .I_OUT_LATCH(latch), .I_SUPPLY(supply), .O_SEARCH_RESPONSE(resp), .O_STROBE_ROLE(strobe_output_role),
    .O_OVERDRIVE(od), .O_SAMPLE(samp));
  csc_chk i_csc_chk (.I_CORE_CLK(clk), .I_RST_N(rst_n), .bus_reset(link.bus_reset), .rom_done(link.rom_done),
    .m_valid(link.m_valid), .m_byte(link.m_byte), .rd_req(link.rd_req), .d_valid(link.d_valid),
    .d_byte(link.d_byte), .d_sample(link.d_sample), .overdrive_flag(link.overdrive_flag));
  // clock and pin snapshot counter
  always #5 clk = ~clk;
  always @(posedge clk) if (samp === 1'b1) n_samp++;
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic fail(input string m);
    $display("FAIL %0t %s", $time, m);
    mismatches++;
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) fail($sformatf("got %h expected %h", got, want));
  endtask : chk
  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    av_addr <= a;
    av_wr <= w;
    av_rd <= ~w;
    av_wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (av_wait !== 1'b0 && n < 100);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (av_wait !== 1'b0) begin
      fail("bus timeout");
      stop_test();
    end
    @(posedge clk);
  endtask : av
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(a, 1'b1, d, q);
  endtask : wr
  // poll status until the sequencer is idle
  task automatic idle();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h1;
    while (q[1:0] !== 2'h0 && n < 100) begin
      av(csc_pkg::REG_STATUS, 1'b0, 32'h0, q);
      n++;
    end
    if (q[1:0] !== 2'h0) begin
      fail("sequencer timeout");
      stop_test();
    end
  endtask : idle
  task automatic op(input logic [31:0] c, input logic [15:0] a, input logic [7:0] d);
    wr(csc_pkg::REG_ADDR, {16'h0, a});
    wr(csc_pkg::REG_WDATA, {24'h0, d});
    wr(csc_pkg::REG_CMD, c);
    idle();
  endtask : op
  task automatic more(input logic [7:0] d);
    wr(csc_pkg::REG_WDATA, {24'h0, d});
    wr(csc_pkg::REG_CMD, 32'h400);
    idle();
  endtask : more
  task automatic rb(output logic [7:0] b);
    logic [31:0] q;
    wr(csc_pkg::REG_CMD, 32'h200);
    idle();
    av(csc_pkg::REG_RDATA, 1'b0, 32'h0, q);
    b = q[7:0];
  endtask : rb
  // page read: data compared, crc left to the checker, trailing ones compared
  task automatic pg(input logic [15:0] a, input int nd, input int tot);
    logic [7:0] b;
    op(32'h0, a, 8'h00);
    for (int i = 0; i < tot; i++) begin
      rb(b);
      if (i < nd) chk({24'h0, b}, {24'h0, expb[i]});
      if (i > nd + 1) chk({24'h0, b}, 32'hFF);
    end
    // trailing ones only end with a bus reset
    op(32'h100, 16'h0000, 8'h00);
  endtask : pg
  task automatic srch(input logic [15:0] a, input logic [7:0] d);
    op(32'h2, a, d);
    op(32'h100, a, d);
  endtask : srch
  // main sequence
  initial begin
    logic [31:0] q;
    logic [7:0] b;
    int n;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, resp}, 32'h1);
    chk({31'h0, strobe_output_role}, 32'h0);
    chk({31'h0, od}, 32'h0);
    av(3'h5, 1'b0, 32'h0, q);
    chk(q, csc_pkg::BAD_READ);
    expb = '{pins, latch, act, 8'h00, 8'h00, csc_pkg::CONTROL_RESET, 8'hFF, 8'hFF};
    n_samp = 0;
    pg(csc_pkg::ADDR_LOGIC, 8, 12);
    chk(n_samp, 32'h1);
    supply <= 1'b1;
    op(32'h2, csc_pkg::ADDR_MASK, 8'h05);
    more(8'h01);
    more(8'h77);
    more(8'hFF);
    op(32'h100, 16'h0000, 8'h00);
    chk({31'h0, strobe_output_role}, 32'h1);
    srch(csc_pkg::ADDR_ACTIVITY, 8'hFF);
    expb = '{8'h05, 8'h01, 8'h87, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    n_samp = 0;
    pg(csc_pkg::ADDR_MASK, 5, 9);
    chk(n_samp, 32'h0);
    // response table: control, pins, latches, expected answer
    foreach (tbl[i]) begin
      srch(csc_pkg::ADDR_CONTROL, tbl[i][31:24]);
      pins <= tbl[i][23:16];
      act <= tbl[i][15:8];
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (resp !== tbl[i][0] && n < 8);
      chk({31'h0, resp}, {31'h0, tbl[i][0]});
    end
    pins <= 8'h5A;
    op(32'h1, 16'h0000, 8'h00);
    for (int i = 0; i < 36; i++) begin
      rb(b);
      if (i < 32 || i > 33) chk({24'h0, b}, 32'h5A);
    end
    op(32'h100, 16'h0000, 8'h00);
    expb = '{default: 8'hFF};
    pg(16'h008E, 2, 4);
    // overdrive is taken only when an operation starts
    op(32'h10, 16'h008E, 8'h00);
    chk({31'h0, od}, 32'h1);
    stop_test();
  end
endmodule : csc_tb_top
